// ---- design/smic_regs.vh ----
`ifndef SMIC_REGS_VH
`define SMIC_REGS_VH
// Overview of operation
// - sixteen-bit counter; loads of one or two up to 65,536 counts, zero meaning 65,536.
// - count clock is the internal 10MHz tick or the external clock, software selected.
// - gate rising edge is a trigger; each rising clock edge is one count.
// - mode 0 load drives output low; high at zero until the next load.
// - mode 0 waits for a gate trigger before it starts decrementing.
// - mode 1 output low on the count after a trigger, high at zero.
// - mode 1 any further trigger reloads the count and restarts the pulse.
// - mode 2 divides by N; output low one count, reload, repeat.
// - mode 2 runs continuously from a load with gate high or from a trigger, stops only while gate is low.
// - mode 3 square wave; odd N high (N+1)/2, low (N-1)/2 counts.
// - mode 3 steps down by two each half, reloading before the opposite half.
// - mode 4 load sets output high and counts; one low count at zero.
// - mode 4 gate low suspends counting while it stays low.
// - mode 5 counts after a gate rising edge; one low count at terminal count.
// - mode 5 retriggers; low pulse only a full count after the latest edge.

// register byte offsets
`define SMIC_OFS_CTRL     12'h000
`define SMIC_OFS_LOAD_LO  12'h004
`define SMIC_OFS_LOAD_HI  12'h008
`define SMIC_OFS_STATUS   12'h00C
`define SMIC_OFS_COUNT    12'h010
// control fields
`define SMIC_CTRL_MODE_LSB  0
`define SMIC_CTRL_MODE_MSB  2
`define SMIC_CTRL_CLKSEL    3
// status fields
`define SMIC_STAT_OUT       0
`define SMIC_STAT_RUN       1
`define SMIC_STAT_WAIT      2
`define SMIC_STAT_GATE      3
`define SMIC_STAT_LOADED    4
// reset values
`define SMIC_RST_MODE       3'h0
`define SMIC_RST_CLKSEL     1'b0
`define SMIC_RST_COUNT      16'h0000
// timing: internal count clock built from the reference clock
`define SMIC_REF_CLK_KHZ    125000
`define SMIC_INT_CLK_KHZ    10000
`define SMIC_ACC_W          17
`endif

// ---- design/smic_top.v ----
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "smic_regs.vh"
module smic_top #(
  parameter CNT_W = 16
) (
  input  wire              ref_clk,
  input  wire              rstn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              ctr_clk_pin,
  input  wire              ctr_gate_pin,
  output reg               ctr_out
);

  localparam [`SMIC_ACC_W-1:0] ACC_STEP = `SMIC_INT_CLK_KHZ;
  localparam [`SMIC_ACC_W-1:0] ACC_MOD  = `SMIC_REF_CLK_KHZ;
  localparam [CNT_W-1:0]       CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0]       CNT_TWO  = {{(CNT_W-2){1'b0}}, 2'b10};

  reg  [`SMIC_ACC_W-1:0] acc_ff;
  reg  [`SMIC_ACC_W-1:0] nxt_acc;
  reg                    int_tick_ff;
  reg  [2:0]             clk_sync_ff;
  reg  [2:0]             gate_sync_ff;
  reg  [2:0]             mode_ff;
  reg                    clk_sel_ff;
  reg  [7:0]             lo_ff;
  reg  [CNT_W-1:0]       init_ff;
  reg  [CNT_W-1:0]       cnt_ff;
  reg                    run_ff;
  reg                    loaded_ff;
  reg                    load_pend_ff;
  reg                    trig_pend_ff;
  reg  [CNT_W-1:0]       nxt_cnt;
  reg                    nxt_out;
  reg                    nxt_run;
  reg                    nxt_loaded;
  reg  [2:0]             eff_mode;
  reg  [31:0]            rd_data;
  reg                    rd_err;

  wire gate_lvl  = gate_sync_ff[1];
  wire gate_rise = gate_sync_ff[1] & ~gate_sync_ff[2];
  wire ext_rise  = clk_sync_ff[1] & ~clk_sync_ff[2];
  // count clock source chosen by software
  wire tick      = clk_sel_ff ? ext_rise : int_tick_ff;
  wire acc_en    = psel & penable & pready;
  wire wr_en     = acc_en & pwrite & ~pslverr;
  wire ctrl_wr   = wr_en & (paddr == `SMIC_OFS_CTRL);
  wire lo_wr     = wr_en & (paddr == `SMIC_OFS_LOAD_LO);
  // a load commits only on the high byte, so a count is always complete
  wire hi_wr     = wr_en & (paddr == `SMIC_OFS_LOAD_HI);
  wire [CNT_W-1:0] half_hi = init_ff + {{(CNT_W-1){1'b0}}, init_ff[0]};
  wire [CNT_W-1:0] half_lo = init_ff - {{(CNT_W-1){1'b0}}, init_ff[0]};

  // fractional divider: 10MHz average from 125MHz, jitter of one ref period
  always @* begin
    if (acc_ff + ACC_STEP >= ACC_MOD) begin
      nxt_acc = acc_ff + ACC_STEP - ACC_MOD;
    end else begin
      nxt_acc = acc_ff + ACC_STEP;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff       <= {`SMIC_ACC_W{1'b0}};
      int_tick_ff  <= 1'b0;
      clk_sync_ff  <= 3'h0;
      gate_sync_ff <= 3'h0;
    end else begin
      acc_ff       <= nxt_acc;
      int_tick_ff  <= (acc_ff + ACC_STEP >= ACC_MOD);
      // rising edges seen only after two sync stages
      clk_sync_ff  <= {clk_sync_ff[1:0], ctr_clk_pin};
      gate_sync_ff <= {gate_sync_ff[1:0], ctr_gate_pin};
    end
  end

  // modes 6 and 7 alias to 2 and 3
  always @* begin
    case (mode_ff)
      3'd6:    eff_mode = 3'd2;
      3'd7:    eff_mode = 3'd3;
      default: eff_mode = mode_ff;
    endcase
  end

  always @* begin
    nxt_cnt    = cnt_ff;
    nxt_out    = ctr_out;
    nxt_run    = run_ff;
    nxt_loaded = loaded_ff;
    if (ctrl_wr) begin
      // new mode stops the counter and sets the idle output level
      nxt_run    = 1'b0;
      nxt_loaded = 1'b0;
      nxt_out    = (pwdata[`SMIC_CTRL_MODE_MSB:`SMIC_CTRL_MODE_LSB] != 3'd0);
    end else if (tick) begin
      if (!ctr_out && (eff_mode == 3'd4 || eff_mode == 3'd5)) begin
        nxt_out = 1'b1;  // strobe lasts one count
      end
      if (load_pend_ff) begin
        nxt_loaded = 1'b1;
        nxt_cnt    = init_ff;
        case (eff_mode)
          3'd0: begin
            nxt_out = 1'b0;  // load drives output low
            nxt_run = 1'b0;  // hold until trigger
          end
          3'd2: begin
            nxt_out = 1'b1;
            nxt_run = gate_lvl;
          end
          3'd3: begin
            nxt_out = 1'b1;
            nxt_cnt = half_hi;
            nxt_run = gate_lvl;
          end
          3'd4: begin
            nxt_out = 1'b1;  // load starts counting
            nxt_run = 1'b1;
          end
          default: begin
            nxt_run = 1'b0;  // modes 1 and 5 wait for a trigger
          end
        endcase
      end else if (trig_pend_ff && loaded_ff && eff_mode != 3'd4 &&
                   !(eff_mode == 3'd0 && ctr_out)) begin
        // a trigger reloads the full count (half_hi in mode 3), except in mode 4 and in mode 0 once the output is high
        nxt_cnt = (eff_mode == 3'd3) ? half_hi : init_ff;
        nxt_run = 1'b1;
        case (eff_mode)
          3'd1:    nxt_out = 1'b0;  // low on the count after trigger
          3'd0:    nxt_out = 1'b0;
          default: nxt_out = 1'b1;
        endcase
      end else if (run_ff) begin
        case (eff_mode)
          3'd2: begin
            // one low count per N, then reload
            if (cnt_ff == CNT_ONE) begin
              nxt_out = 1'b0;
              nxt_cnt = init_ff;
            end else begin
              nxt_out = 1'b1;
              nxt_cnt = cnt_ff - CNT_ONE;
            end
          end
          3'd3: begin
            // step by two, reload before the opposite half
            if (cnt_ff == CNT_TWO) begin
              nxt_out = ~ctr_out;
              nxt_cnt = ctr_out ? half_lo : half_hi;
            end else begin
              nxt_cnt = cnt_ff - CNT_TWO;
            end
          end
          default: begin
            if (!(eff_mode == 3'd4 && !gate_lvl)) begin  // gate low holds
              nxt_cnt = cnt_ff - CNT_ONE;
              if (cnt_ff == CNT_ONE) begin
                // zero reached: 0 and 1 go high, 4 and 5 strobe low
                nxt_run = 1'b0;
                nxt_out = (eff_mode == 3'd0 || eff_mode == 3'd1);
              end
            end
          end
        endcase
      end
    end
    if (!ctrl_wr && (eff_mode == 3'd2 || eff_mode == 3'd3) && !gate_lvl) begin
      // gate low stops the periodic modes at once
      nxt_run = 1'b0;
      nxt_out = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff      <= `SMIC_RST_MODE;
      clk_sel_ff   <= `SMIC_RST_CLKSEL;
      lo_ff        <= 8'h00;
      init_ff      <= `SMIC_RST_COUNT;
      cnt_ff       <= `SMIC_RST_COUNT;
      run_ff       <= 1'b0;
      loaded_ff    <= 1'b0;
      load_pend_ff <= 1'b0;
      trig_pend_ff <= 1'b0;
      ctr_out      <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      run_ff    <= nxt_run;
      loaded_ff <= nxt_loaded;
      ctr_out   <= nxt_out;
      if (ctrl_wr) begin
        mode_ff    <= pwdata[`SMIC_CTRL_MODE_MSB:`SMIC_CTRL_MODE_LSB];
        clk_sel_ff <= pwdata[`SMIC_CTRL_CLKSEL];
      end
      if (lo_wr) begin
        lo_ff <= pwdata[7:0];
      end
      if (hi_wr) begin
        // zero stands for the full 65,536 range
        init_ff <= {pwdata[CNT_W-9:0], lo_ff};
      end
      // a new load or edge wins over consumption in the same cycle
      load_pend_ff <= hi_wr | (load_pend_ff & ~tick & ~ctrl_wr);
      trig_pend_ff <= gate_rise | (trig_pend_ff & ~tick & ~ctrl_wr & ~hi_wr);
    end
  end

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      `SMIC_OFS_CTRL: begin
        rd_data[`SMIC_CTRL_MODE_MSB:`SMIC_CTRL_MODE_LSB] = mode_ff;
        rd_data[`SMIC_CTRL_CLKSEL] = clk_sel_ff;
      end
      `SMIC_OFS_LOAD_LO: rd_data[7:0] = lo_ff;
      `SMIC_OFS_LOAD_HI: rd_data[CNT_W-1:0] = init_ff;
      `SMIC_OFS_STATUS: begin
        rd_data[`SMIC_STAT_OUT]    = ctr_out;
        rd_data[`SMIC_STAT_RUN]    = run_ff;
        rd_data[`SMIC_STAT_WAIT]   = load_pend_ff | (loaded_ff & ~run_ff);
        rd_data[`SMIC_STAT_GATE]   = gate_lvl;
        rd_data[`SMIC_STAT_LOADED] = loaded_ff;
      end
      `SMIC_OFS_COUNT: rd_data[CNT_W-1:0] = cnt_ff;
      default: rd_err = 1'b1;
    endcase
  end

  // answer is prepared in the setup cycle so the access phase has no wait
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      pready  <= 1'b1;
      pslverr <= rd_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- verif/smic_props.sv ----
`timescale 1ns/100ps
module smic_props (
  input wire        ref_clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire bad = (paddr > 12'h010) || (paddr[1:0] != 2'h0);
  // zero wait states: the answer is due one cycle after setup
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_acc; pready |-> psel && penable && $past(psel && !penable); endproperty
  a_acc: assert property (p_acc) else $error("answer outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_wr; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("read data on write");
  property p_bad; pready && bad |-> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped not refused");
  property p_ok; pready && !bad |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_rstn; $rose(rstn) |-> !pready && !pslverr; endproperty
  a_rstn: assert property (@(posedge ref_clk) p_rstn) else $error("bus busy at reset");
endmodule

// ---- verif/smic_src.sv ----
`timescale 1ns/100ps
module smic_src (
  input  wire ref_clk,
  output reg  ctr_clk_pin,
  output reg  ctr_gate_pin
);
  initial begin
    ctr_clk_pin = 1'b0;
    ctr_gate_pin = 1'b0;
  end
  // clock stands still between ticks so each count is placed exactly
  task tick;
    begin
      @(posedge ref_clk) ctr_clk_pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      ctr_clk_pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  // settle time covers the two-stage sync in the counter
  task gate(input v);
    begin
      @(posedge ref_clk) ctr_gate_pin <= v;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// ---- verif/tb_smic_top.sv ----
`timescale 1ns/100ps
module tb_smic_top;
  reg         ref_clk;
  reg         rstn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        ctr_clk_pin;
  wire        ctr_gate_pin;
  wire        ctr_out;
  reg  [31:0] rd;
  reg         er;
  integer     n_fail;
  integer     n_compared;
  smic_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctr_clk_pin(ctr_clk_pin), .ctr_gate_pin(ctr_gate_pin),
    .ctr_out(ctr_out));
  smic_src u_src (.ref_clk(ref_clk), .ctr_clk_pin(ctr_clk_pin), .ctr_gate_pin(ctr_gate_pin));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task test_done;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && i < 40) begin
        @(posedge ref_clk);
        i = i + 1;
      end
      if (i >= 40) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: no bus answer", $time);
        test_done;
      end
      // answer taken at the same rising edge that samples pready high
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task load(input [3:0] c, input [15:0] n);
    begin
      apb(1'b1, 12'h000, {28'h0, c});
      apb(1'b1, 12'h004, {24'h0, n[7:0]});
      apb(1'b1, 12'h008, {24'h0, n[15:8]});
      u_src.tick;
    end
  endtask
  task lows(input integer n, input integer e);
    integer i;
    integer c;
    begin
      c = 0;
      for (i = 0; i < n; i = i + 1) begin
        u_src.tick;
        @(negedge ref_clk);
        if (ctr_out === 1'b0) c = c + 1;
      end
      chk(c, e);
    end
  endtask
  task t_regs;
    begin
      load(4'h8, 16'h1234);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h1234);
      apb(1'b0, 12'h014, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
    end
  endtask
  task t_m0;
    begin
      load(4'h8, 16'd3);
      lows(5, 5);
      u_src.gate(1'b1);
      lows(3, 3);
      lows(4, 0);
    end
  endtask
  task t_m1;
    begin
      u_src.gate(1'b0);
      load(4'h9, 16'd4);
      lows(2, 0);
      u_src.gate(1'b1);
      lows(3, 3);
      u_src.gate(1'b0);
      u_src.gate(1'b1);
      lows(4, 4);
      lows(2, 0);
    end
  endtask
  task t_m23;
    begin
      load(4'hA, 16'd3);
      lows(6, 2);
      u_src.gate(1'b0);
      lows(6, 0);
      u_src.gate(1'b1);
      load(4'hB, 16'd5);
      lows(10, 4);
      load(4'hB, 16'd4);
      lows(8, 4);
    end
  endtask
  task t_m45;
    begin
      load(4'hC, 16'd3);
      lows(8, 1);
      u_src.gate(1'b0);
      load(4'hC, 16'd3);
      lows(6, 0);
      u_src.gate(1'b1);
      lows(5, 1);
      u_src.gate(1'b0);
      load(4'hD, 16'd4);
      lows(6, 0);
      u_src.gate(1'b1);
      lows(2, 0);
      u_src.gate(1'b0);
      u_src.gate(1'b1);
      lows(3, 0);
      lows(3, 1);
    end
  endtask
  // internal tick has one-cycle jitter, so the pulse count gets a margin of one
  task t_int;
    integer i;
    integer c;
    reg p;
    begin
      load(4'h2, 16'd10);
      c = 0;
      p = ctr_out;
      for (i = 0; i < 1250; i = i + 1) begin
        @(negedge ref_clk);
        if (p === 1'b1 && ctr_out === 1'b0) c = c + 1;
        p = ctr_out;
      end
      chk(c >= 9 && c <= 11, 1);
    end
  endtask
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs;
    t_m0;
    t_m1;
    t_m23;
    t_m45;
    t_int;
    test_done;
  end
endmodule
bind smic_top smic_props u_props (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
